/* File: external_data_memory_port.sv */
// external data memory port: address forming, memory map, multiplexed pin cycle
`include "xmem_params.svh"
`timescale 1ns/100ps
`default_nettype none

module external_data_memory_port (
    input wire logic CLK,
    input wire logic RESETN,
    // special function register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // external move instruction from the core
    input wire logic XMOVE_REQ,
    input wire logic XMOVE_WRITE,
    input wire logic XMOVE_FORM16,
    input wire logic XMOVE_INDEX_SEL,
    input wire logic [7:0] FIRST_INDEX,
    input wire logic [7:0] SECOND_INDEX,
    input wire logic [7:0] XMOVE_WDATA,
    output logic [7:0] XMOVE_RDATA,
    output logic XMOVE_DONE,
    output logic XMOVE_BUSY,
    // on-chip data memory
    output logic XRAM_EN,
    output logic XRAM_WE,
    output logic [10:0] XRAM_ADDR,
    output logic [7:0] XRAM_WDATA,
    input wire logic [7:0] XRAM_RDATA,
    // port latch / crossbar values that own the pins when idle
    input wire logic [7:0] PORT1_IDLE_OUT,
    input wire logic [7:0] PORT1_IDLE_OE_N,
    input wire logic [7:0] PORT2_IDLE_OUT,
    input wire logic [7:0] PORT2_IDLE_OE_N,
    input wire logic [7:0] PORT3_IDLE_OUT,
    input wire logic [7:0] PORT3_IDLE_OE_N,
    // shared address/data pins, read back from the pads
    input wire logic [7:0] PORT3_IN,
    // pin drive; output mode stays with the port configuration
    output logic [7:0] PORT1_OUT,
    output logic [7:0] PORT1_OE_N,
    output logic [7:0] PORT2_OUT,
    output logic [7:0] PORT2_OE_N,
    output logic [7:0] PORT3_OUT,
    output logic [7:0] PORT3_OE_N,
    output logic PORT_CLAIMED
);
    import xmem_pkg::*;

    access_state_t state_q, state_d;
    logic [7:0] page_q;
    logic [7:0] dp_high_q;
    logic [7:0] dp_low_q;
    memory_mode_t mode_q;
    logic [1:0] width_q;
    logic [7:0] sfr_rdata_q;
    logic [15:0] addr_q;
    logic write_q;
    logic offchip_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic done_q;
    logic [7:0] p3_meta_q;
    logic [7:0] p3_sync_q;
    logic [7:0] p1_out_q, p1_oe_n_q, p2_out_q, p2_oe_n_q, p3_out_q, p3_oe_n_q;

    // register decode
    wire hit_page = (SFR_ADDR == `XMEM_PAGE_SELECT_ADDR);
    wire hit_config = (SFR_ADDR == `XMEM_CONFIG_ADDR);
    wire hit_dp_high = (SFR_ADDR == `XMEM_DP_HIGH_ADDR);
    wire hit_dp_low = (SFR_ADDR == `XMEM_DP_LOW_ADDR);
    // upper config bits are unused or reserved and read as zero
    wire [7:0] config_view = {4'h0, mode_q, width_q};
    wire [7:0] sfr_rdata_d = hit_page ? page_q :
                             hit_config ? config_view :
                             hit_dp_high ? dp_high_q :
                             hit_dp_low ? dp_low_q : 8'h00;

    // address forming
    wire [7:0] index_sel = XMOVE_INDEX_SEL ? SECOND_INDEX : FIRST_INDEX;
    wire [15:0] data_pointer = {dp_high_q, dp_low_q};
    wire [15:0] paged_addr = {page_q, index_sel};
    wire [15:0] logical_addr = XMOVE_FORM16 ? data_pointer : paged_addr;
    wire below_boundary = (logical_addr < `XMEM_ONCHIP_BOUNDARY);

    // memory map: the split decision uses the page register, not the latch
    wire go_offchip = (mode_q == MODE_EXTERNAL) ||
                      ((mode_q != MODE_INTERNAL) && !below_boundary);
    // high byte replaced by the port2 latch only in split without bank
    wire use_latch_high = (mode_q == MODE_SPLIT_NO_BANK) && !XMOVE_FORM16;
    wire [15:0] offchip_addr = use_latch_high ? {PORT2_IDLE_OUT, index_sel} : logical_addr;
    wire [15:0] target_addr = go_offchip ? offchip_addr : logical_addr;

    // phase timing
    wire [2:0] latch_cycles = {1'b0, width_q} + 3'h1;
    logic timer_load;
    logic [2:0] timer_cycles;
    logic phase_last;

    xmem_phase_timer u_timer (
        .clk(CLK),
        .resetn(RESETN),
        .load(timer_load),
        .cycles(timer_cycles),
        .last(phase_last)
    );

    // sequencer for one access
    always_comb begin
        state_d = state_q;
        timer_load = 1'b0;
        timer_cycles = latch_cycles;
        unique case (state_q)
            ST_IDLE: begin
                if (XMOVE_REQ) begin
                    timer_load = go_offchip;
                    state_d = go_offchip ? ST_LATCH_HIGH : ST_ONCHIP;
                end
            end
            ST_ONCHIP: begin
                state_d = ST_FINISH;
            end
            ST_LATCH_HIGH: begin
                if (phase_last) begin
                    timer_load = 1'b1;
                    state_d = ST_LATCH_LOW;
                end
            end
            ST_LATCH_LOW: begin
                if (phase_last) begin
                    timer_load = 1'b1;
                    timer_cycles = `XMEM_STROBE_CYCLES;
                    state_d = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (phase_last) begin
                    state_d = ST_FINISH;
                end
            end
            ST_FINISH: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // pin claim: only from the first latch phase to the finish cycle
    wire claim = offchip_q && (state_q != ST_IDLE) && (state_q != ST_ONCHIP);
    wire addr_phase = (state_q == ST_LATCH_HIGH) || (state_q == ST_LATCH_LOW);
    wire strobe_phase = (state_q == ST_STROBE);
    wire drive_ad = addr_phase || (write_q && (strobe_phase || state_q == ST_FINISH));

    // next pin values; idle owners take back the pins when not claimed
    wire [7:0] p1_strobes = {!(strobe_phase && write_q), !(strobe_phase && !write_q),
                             (state_q == ST_LATCH_HIGH), 5'h00};
    wire [7:0] p1_claim_mask = 8'he0;
    wire [7:0] p1_out_d = claim ? ((PORT1_IDLE_OUT & ~p1_claim_mask) | p1_strobes)
                                : PORT1_IDLE_OUT;
    wire [7:0] p1_oe_n_d = claim ? (PORT1_IDLE_OE_N & ~p1_claim_mask) : PORT1_IDLE_OE_N;
    wire [7:0] p2_out_d = claim ? addr_q[15:8] : PORT2_IDLE_OUT;
    wire [7:0] p2_oe_n_d = claim ? 8'h00 : PORT2_IDLE_OE_N;
    // low address while latching, data while writing, released for reads
    wire [7:0] p3_out_d = !claim ? PORT3_IDLE_OUT :
                          addr_phase ? addr_q[7:0] : wdata_q;
    wire [7:0] p3_oe_n_d = !claim ? PORT3_IDLE_OE_N :
                           drive_ad ? 8'h00 : 8'hff;

    // read data: on-chip in the finish cycle, off-chip at strobe end
    wire capture_onchip = (state_q == ST_FINISH) && !offchip_q && !write_q;
    wire capture_offchip = strobe_phase && phase_last && !write_q;

    // state and access registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            addr_q <= 16'h0000;
            write_q <= 1'b0;
            offchip_q <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && XMOVE_REQ) begin
                addr_q <= target_addr;
                write_q <= XMOVE_WRITE;
                offchip_q <= go_offchip;
                wdata_q <= XMOVE_WDATA;
            end
        end
    end

    // software registers; writes land even mid-access, the access keeps its address copy but the low latch phase takes width_q live
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            page_q <= `XMEM_PAGE_SELECT_RESET;
            dp_high_q <= `XMEM_DP_RESET;
            dp_low_q <= `XMEM_DP_RESET;
            mode_q <= memory_mode_t'(2'(`XMEM_CONFIG_RESET >> `XMEM_CFG_MODE_LO));
            width_q <= 2'(`XMEM_CONFIG_RESET);
            sfr_rdata_q <= 8'h00;
        end else begin
            if (SFR_WR && hit_page) page_q <= SFR_WDATA;
            if (SFR_WR && hit_dp_high) dp_high_q <= SFR_WDATA;
            if (SFR_WR && hit_dp_low) dp_low_q <= SFR_WDATA;
            if (SFR_WR && hit_config) begin
                mode_q <= memory_mode_t'(SFR_WDATA[`XMEM_CFG_MODE_HI:`XMEM_CFG_MODE_LO]);
                width_q <= SFR_WDATA[`XMEM_CFG_WIDTH_HI:`XMEM_CFG_WIDTH_LO];
            end
            if (SFR_RD) sfr_rdata_q <= sfr_rdata_d;
        end
    end

    // pad input synchroniser; the data bus is asynchronous to us
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p3_meta_q <= 8'h00;
            p3_sync_q <= 8'h00;
        end else begin
            p3_meta_q <= PORT3_IN;
            p3_sync_q <= p3_meta_q;
        end
    end

    // read data and completion
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            if (capture_onchip) rdata_q <= XRAM_RDATA;
            if (capture_offchip) rdata_q <= p3_sync_q;
            done_q <= (state_q == ST_FINISH);
        end
    end

    // registered pin drive; mode bits never pass through here
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p1_out_q <= 8'hff;
            p1_oe_n_q <= 8'hff;
            p2_out_q <= 8'hff;
            p2_oe_n_q <= 8'hff;
            p3_out_q <= 8'hff;
            p3_oe_n_q <= 8'hff;
        end else begin
            p1_out_q <= p1_out_d;
            p1_oe_n_q <= p1_oe_n_d;
            p2_out_q <= p2_out_d;
            p2_oe_n_q <= p2_oe_n_d;
            p3_out_q <= p3_out_d;
            p3_oe_n_q <= p3_oe_n_d;
        end
    end

    // on-chip memory: addresses alias into the 2 kB space
    assign XRAM_EN = (state_q == ST_ONCHIP);
    assign XRAM_WE = (state_q == ST_ONCHIP) && write_q;
    assign XRAM_ADDR = addr_q[`XMEM_ONCHIP_ADDR_BITS-1:0];
    assign XRAM_WDATA = wdata_q;

    // outputs
    assign SFR_RDATA = sfr_rdata_q;
    assign XMOVE_RDATA = rdata_q;
    assign XMOVE_DONE = done_q;
    assign XMOVE_BUSY = (state_q != ST_IDLE) || done_q;
    assign PORT1_OUT = p1_out_q;
    assign PORT1_OE_N = p1_oe_n_q;
    assign PORT2_OUT = p2_out_q;
    assign PORT2_OE_N = p2_oe_n_q;
    assign PORT3_OUT = p3_out_q;
    assign PORT3_OE_N = p3_oe_n_q;
    assign PORT_CLAIMED = claim;
endmodule // external_data_memory_port

`default_nettype wire

/* File: external_data_memory_port_tb_top.sv */
// self-checking bench for the external data memory port
`include "xmem_params.svh"
`timescale 1ns/100ps
`default_nettype none
module external_data_memory_port_tb_top;
    import xmem_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic SFR_WR = 1'b0, SFR_RD = 1'b0, XMOVE_REQ = 1'b0, XMOVE_WRITE = 1'b0;
    logic XMOVE_FORM16 = 1'b0, XMOVE_INDEX_SEL = 1'b0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, FIRST_INDEX = 8'h00, SECOND_INDEX = 8'h00;
    logic [7:0] XMOVE_WDATA = 8'h00, XRAM_RDATA = 8'h00, PORT2_IDLE_OUT = 8'hff;
    // parked at one and driven between accesses
    logic [7:0] PORT1_IDLE_OUT = 8'hff, PORT3_IDLE_OUT = 8'hff;
    // crossbar leaves the strobe pins to the port, so idle owners are plain latches
    logic [7:0] PORT1_IDLE_OE_N = 8'h00, PORT2_IDLE_OE_N = 8'h00, PORT3_IDLE_OE_N = 8'h00;
    logic [7:0] SFR_RDATA, XMOVE_RDATA, XRAM_WDATA, PORT3_IN, PORT1_OUT, PORT2_OUT, PORT3_OUT;
    logic [7:0] PORT1_OE_N, PORT2_OE_N, PORT3_OE_N;
    logic [10:0] XRAM_ADDR;
    logic XMOVE_DONE, XMOVE_BUSY, XRAM_EN, XRAM_WE, PORT_CLAIMED;
    logic [7:0] xram [0:2047];
    int miscompares = 0, n_tests = 0, cycles = 0;
    external_data_memory_port i_dut (.*);
    xmem_sram_model i_mem (.P1(PORT1_OUT), .P2(PORT2_OUT), .P3_OUT(PORT3_OUT),
        .P3_OE_N(PORT3_OE_N), .P3_IN(PORT3_IN));
    always #5 CLK = ~CLK;
    // on-chip memory, data one cycle after enable; cycle ceiling cuts a hang
    always @(posedge CLK) begin
        if (XRAM_EN === 1'b1) begin
            if (XRAM_WE === 1'b1) xram[XRAM_ADDR] <= XRAM_WDATA;
            XRAM_RDATA <= xram[XRAM_ADDR];
        end
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            results();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register access; a read compares the answer one cycle later
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WR <= wr;
        SFR_RD <= ~wr;
        @(posedge CLK);
        SFR_WR <= 1'b0;
        SFR_RD <= 1'b0;
        #1;
        if (!wr) check(SFR_RDATA, d);
    endtask
    task automatic set_dp(input logic [15:0] a);
        sfr(1'b1, `XMEM_DP_HIGH_ADDR, a[15:8]);
        sfr(1'b1, `XMEM_DP_LOW_ADDR, a[7:0]);
    endtask
    // one access; the unused index holds a decoy so a wrong pick shows
    task automatic xmove(input logic wr, input logic f16, input logic sel, input logic [7:0] idx,
        input logic [7:0] wd);
        @(posedge CLK);
        XMOVE_REQ <= 1'b1;
        XMOVE_WRITE <= wr;
        XMOVE_FORM16 <= f16;
        XMOVE_INDEX_SEL <= sel;
        FIRST_INDEX <= sel ? ~idx : idx;
        SECOND_INDEX <= sel ? idx : ~idx;
        XMOVE_WDATA <= wd;
        @(posedge CLK);
        XMOVE_REQ <= 1'b0;
        for (int i = 0; i < 30 && XMOVE_DONE !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        check({7'h00, XMOVE_DONE}, 8'h01);
    endtask
    task automatic t_regs();
        sfr(1'b0, `XMEM_CONFIG_ADDR, 8'h03);
        sfr(1'b0, `XMEM_PAGE_SELECT_ADDR, 8'h00);
        sfr(1'b0, `XMEM_DP_LOW_ADDR, 8'h00);
        set_dp(16'habcd);
        sfr(1'b1, 8'h55, 8'h77);
        sfr(1'b0, `XMEM_DP_HIGH_ADDR, 8'hab);
        sfr(1'b0, `XMEM_DP_LOW_ADDR, 8'hcd);
        sfr(1'b0, 8'h55, 8'h00);
    endtask
    // every mode, the split boundary, and where the high byte comes from
    task automatic t_map();
        // pins and latches are parked before the mode is chosen
        sfr(1'b1, `XMEM_CONFIG_ADDR, {4'h0, MODE_INTERNAL, 2'h3});
        sfr(1'b1, `XMEM_PAGE_SELECT_ADDR, 8'h12);
        set_dp(16'h1234);
        xmove(1'b1, 1'b1, 1'b0, 8'h00, 8'h5a);
        check(xram[11'h234], 8'h5a);
        xmove(1'b0, 1'b0, 1'b1, 8'h34, 8'h00);
        check(XMOVE_RDATA, 8'h5a);
        sfr(1'b1, `XMEM_CONFIG_ADDR, {4'h0, MODE_SPLIT_BANK, 2'h0});
        xmove(1'b1, 1'b1, 1'b0, 8'h00, 8'h3d);
        check(i_mem.mem[16'h1234], 8'h3d);
        set_dp(16'h07ff);
        xmove(1'b1, 1'b1, 1'b0, 8'h00, 8'h3c);
        check(xram[11'h7ff], 8'h3c);
        sfr(1'b1, `XMEM_CONFIG_ADDR, {4'h0, MODE_EXTERNAL, 2'h1});
        xmove(1'b1, 1'b1, 1'b0, 8'h00, 8'h11);
        check(i_mem.mem[16'h07ff], 8'h11);
        check(xram[11'h7ff], 8'h3c);
        sfr(1'b1, `XMEM_CONFIG_ADDR, {4'h0, MODE_SPLIT_NO_BANK, 2'h1});
        PORT2_IDLE_OUT <= 8'h9a;
        sfr(1'b1, `XMEM_PAGE_SELECT_ADDR, 8'h55);
        xmove(1'b1, 1'b0, 1'b0, 8'h21, 8'h4e);
        check(i_mem.mem[16'h9a21], 8'h4e);
    endtask
    // off-chip write then read back at each latch strobe width, top page
    task automatic t_widths();
        sfr(1'b1, `XMEM_PAGE_SELECT_ADDR, 8'hff);
        for (int w = 0; w < 4; w++) begin
            sfr(1'b1, `XMEM_CONFIG_ADDR, {4'h0, MODE_EXTERNAL, w[1:0]});
            set_dp({8'hff, 8'hf0 + w[7:0]});
            xmove(1'b1, 1'b1, 1'b0, 8'h00, 8'hc0 + w[7:0]);
            check(i_mem.mem[{8'hff, 8'hf0 + w[7:0]}], 8'hc0 + w[7:0]);
            xmove(1'b0, 1'b0, w[0], 8'hf0 + w[7:0], 8'h00);
            check(XMOVE_RDATA, 8'hc0 + w[7:0]);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge CLK);
        RESETN <= 1'b1;
        t_regs();
        t_map();
        t_widths();
        results();
    end
endmodule // external_data_memory_port_tb_top
`default_nettype wire

/* File: xmem_params.svh */
// constants for the external data memory port
`ifndef XMEM_PARAMS_SVH
`define XMEM_PARAMS_SVH

// special function register addresses
`define XMEM_PAGE_SELECT_ADDR 8'haa
`define XMEM_CONFIG_ADDR 8'hb2
`define XMEM_DP_HIGH_ADDR 8'h83
`define XMEM_DP_LOW_ADDR 8'h82

// reset values
`define XMEM_PAGE_SELECT_RESET 8'h00
`define XMEM_CONFIG_RESET 8'h03
`define XMEM_DP_RESET 8'h00

// config register field positions
`define XMEM_CFG_MODE_HI 3
`define XMEM_CFG_MODE_LO 2
`define XMEM_CFG_WIDTH_HI 1
`define XMEM_CFG_WIDTH_LO 0

// on-chip space ends at the 2 kB boundary
`define XMEM_ONCHIP_BOUNDARY 16'h0800
`define XMEM_ONCHIP_ADDR_BITS 11

// strobe pin positions on port 1
`define XMEM_LATCH_STROBE_BIT 5
`define XMEM_READ_STROBE_BIT 6
`define XMEM_WRITE_STROBE_BIT 7

// read/write strobe low time, in system clock cycles
`define XMEM_STROBE_CYCLES 3'd6

`endif

/* File: xmem_phase_timer.sv */
// down counter that times each phase of an off-chip cycle
`timescale 1ns/100ps
`default_nettype none

module xmem_phase_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [2:0] cycles,
    output logic last
);
    logic [2:0] count_q;
    logic [2:0] count_d;

    // load cycles-1 so that a phase lasts exactly 'cycles' clocks
    assign count_d = load ? (cycles - 3'h1) : ((count_q == 3'h0) ? 3'h0 : count_q - 3'h1);
    // last must not look at load: the sequencer derives load from last
    assign last = (count_q == 3'h0);

    // counter
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_q <= 3'h0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // xmem_phase_timer

`default_nettype wire

/* File: xmem_pkg.sv */
// types for the external data memory port
package xmem_pkg;

    typedef enum logic [1:0] {
        MODE_INTERNAL = 2'h0,
        MODE_SPLIT_NO_BANK = 2'h1,
        MODE_SPLIT_BANK = 2'h2,
        MODE_EXTERNAL = 2'h3
    } memory_mode_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ONCHIP = 6'h02,
        ST_LATCH_HIGH = 6'h04,
        ST_LATCH_LOW = 6'h08,
        ST_STROBE = 6'h10,
        ST_FINISH = 6'h20
    } access_state_t;

endpackage

/* File: xmem_port_props.sv */
// checker for the external data memory port pin cycle
`include "xmem_params.svh"
`timescale 1ns/100ps
`default_nettype none
module xmem_port_props (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic XMOVE_REQ,
    input wire logic XMOVE_BUSY,
    input wire logic XMOVE_DONE,
    input wire logic XRAM_EN,
    input wire logic PORT_CLAIMED,
    input wire logic [7:0] PORT1_IDLE_OUT,
    input wire logic [7:0] PORT3_IDLE_OE_N,
    input wire logic [7:0] PORT1_OUT,
    input wire logic [7:0] PORT3_OE_N
);
    logic [2:0] width_q;
    logic [4:0] claim_q;
    wire strobes_high = PORT1_OUT[6] & PORT1_OUT[7];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // shadow of the latch strobe width; only valid while no write lands mid-access
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            width_q <= 3'd4;
        end else if (SFR_WR && SFR_ADDR == `XMEM_CONFIG_ADDR) begin
            width_q <= {1'b0, SFR_WDATA[1:0]} + 3'd1;
        end
    end
    // cycles since the pins were claimed
    always_ff @(posedge CLK) begin
        claim_q <= (!RESETN || !PORT_CLAIMED) ? 5'd0 : claim_q + 5'd1;
    end
    property p_idle;
        $past(RESETN) && !$past(PORT_CLAIMED) |->
            PORT1_OUT == $past(PORT1_IDLE_OUT) && PORT3_OE_N == $past(PORT3_IDLE_OE_N);
    endproperty
    a_idle: assert property (p_idle) else $error("pins not back with latches");
    property p_onchip;
        XRAM_EN |-> !PORT_CLAIMED ##2 XMOVE_DONE;
    endproperty
    a_onchip: assert property (p_onchip) else $error("on-chip access wrong");
    property p_busy;
        XMOVE_REQ && !XMOVE_BUSY |=> XMOVE_BUSY [*3];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not held");
    property p_ale;
        PORT_CLAIMED && $fell(PORT1_OUT[5]) |-> claim_q == {2'b00, width_q} + 5'd1;
    endproperty
    a_ale: assert property (p_ale) else $error("latch strobe high width");
    property p_strobe_at;
        PORT_CLAIMED && $fell(strobes_high) |-> claim_q == {1'b0, width_q, 1'b0} + 5'd1;
    endproperty
    a_strobe_at: assert property (p_strobe_at) else $error("latch strobe low width");
    property p_strobe_len;
        PORT_CLAIMED && $fell(strobes_high) |-> !strobes_high [*6] ##1 strobes_high && XMOVE_DONE;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
    property p_read_off;
        !PORT1_OUT[6] && $past(PORT_CLAIMED) |-> PORT3_OE_N == 8'hff;
    endproperty
    a_read_off: assert property (p_read_off) else $error("data driven in read");
    property p_addr_held;
        PORT_CLAIMED && $fell(PORT1_OUT[5]) |-> PORT3_OE_N == 8'h00 && $past(PORT3_OE_N) == 8'h00;
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("low address dropped");
endmodule // xmem_port_props
bind external_data_memory_port xmem_port_props i_props (.*);
`default_nettype wire

/* File: xmem_sram_model.sv */
// off-chip byte memory behind an address latch on the multiplexed pins
`timescale 1ns/100ps
`default_nettype none
module xmem_sram_model (
    input wire logic [7:0] P1,
    input wire logic [7:0] P2,
    input wire logic [7:0] P3_OUT,
    input wire logic [7:0] P3_OE_N,
    output logic [7:0] P3_IN
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q;
    logic [7:0] last_q = 8'h00;
    wire [7:0] bus = P1[6] ? ~last_q : mem[addr_q];
    // latch keeps address when the latch strobe falls
    always @(negedge P1[5]) addr_q = {P2, P3_OUT};
    // write lands at the trailing edge of the write strobe
    always @(posedge P1[7]) mem[addr_q] = P3_OUT;
    // released bus shows the inverse, so stale data never passes
    always @(posedge P1[6]) last_q = mem[addr_q];
    assign P3_IN = (P3_OUT & ~P3_OE_N) | (bus & P3_OE_N);
endmodule // xmem_sram_model
`default_nettype wire
